// [verilog/tccu_pkg.sv]
// tccu_pkg: register map, field positions, reset values and machine-cycle
// states shared by the timer capture/compare block.
// assumes an 8-bit special function register address space.
package tccu_pkg;

    localparam int TCCU_AW = 8;
    localparam int TCCU_DW = 8;

    // register addresses
    localparam logic [7:0] ADDR_IRQ_FLAGS = 8'hc8;
    localparam logic [7:0] ADDR_TIMER_CTRL = 8'hc9;
    localparam logic [7:0] ADDR_SET_EN = 8'hc0;
    localparam logic [7:0] ADDR_RT_EN = 8'hc1;
    localparam logic [7:0] ADDR_OUT_PORT = 8'hc2;
    localparam logic [7:0] ADDR_EDGE_SEL = 8'heb;
    localparam logic [7:0] ADDR_IRQ_PRIO = 8'hf8;
    // compare regs 0..2 at d0..d5, capture regs 0..3 at e0..e7, low byte even
    localparam logic [4:0] ADDR_CMP_BLOCK = 5'h1a;
    localparam logic [4:0] ADDR_CAP_BLOCK = 5'h1c;

    // field positions
    localparam int FLAG_WIDE_OVF_BIT = 7;
    localparam int FLAG_MATCH0_BIT = 4;
    localparam int FLAG_CAP0_BIT = 0;
    localparam int CTRL_BYTE_OVF_BIT = 4;
    localparam int TOGGLE_LO_BIT = 6;
    localparam int HW_SET_BITS = 6;

    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [1:0] RST_TOGGLE = 2'h3;

    // capture channels whose flag is set in S4 rather than S6
    localparam int EARLY_CAP_CHANNELS = 2;

    typedef enum logic [2:0] {
        ST_S1, ST_S2, ST_S3, ST_S4, ST_S5, ST_S6
    } tccu_state_t;

endpackage

// [verilog/tccu_top.sv]
// tccu_top: capture/compare logic around a 16-bit timer, with the output
// port latch, its toggle flip-flops, the interrupt flags and priorities.
// assumes the timer counter lives outside: it presents its value, a tick
// in the S1 state after each increment, and overflow pulses in a cycle.
// one core_clk period is one state; six states form one machine cycle.
//
// Our own choice: the strobed register port.
`timescale 1ns/100ps
`default_nettype none

module tccu_top
    import tccu_pkg::*;
#(
    parameter int TIMER_W = 16,
    parameter int NUM_CAP = 4,
    parameter int NUM_CMP = 3
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [TCCU_AW-1:0] addr,
    input wire logic [TCCU_DW-1:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [TCCU_DW-1:0] rd_data,
    input wire logic [TIMER_W-1:0] timer_value,
    input wire logic timer_tick,
    input wire logic byte_overflow,
    input wire logic wide_overflow,
    input wire logic capture_input_0,
    input wire logic capture_input_1,
    input wire logic capture_input_2,
    input wire logic capture_input_3,
    output logic [7:0] output_port,
    output logic [7:0] timer_irq_flags,
    output logic byte_overflow_flag,
    output logic [7:0] timer_irq_priority
);

    // machine-cycle state sequencer
    tccu_state_t state_r;
    tccu_state_t state_nxt;

    always_comb begin
        unique case (state_r)
            ST_S1: state_nxt = ST_S2;
            ST_S2: state_nxt = ST_S3;
            ST_S3: state_nxt = ST_S4;
            ST_S4: state_nxt = ST_S5;
            ST_S5: state_nxt = ST_S6;
            ST_S6: state_nxt = ST_S1;
            default: state_nxt = ST_S1;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_r <= ST_S1;
        end else begin
            state_r <= state_nxt;
        end
    end

    wire in_s1 = (state_r == ST_S1);
    wire in_s4 = (state_r == ST_S4);
    wire in_s5 = (state_r == ST_S5);
    wire in_s6 = (state_r == ST_S6);

    // register decode
    wire wr_flags = wr_en && (addr == ADDR_IRQ_FLAGS);
    wire wr_ctrl = wr_en && (addr == ADDR_TIMER_CTRL);
    wire wr_ste = wr_en && (addr == ADDR_SET_EN);
    wire wr_rte = wr_en && (addr == ADDR_RT_EN);
    wire wr_port = wr_en && (addr == ADDR_OUT_PORT);
    wire wr_edge = wr_en && (addr == ADDR_EDGE_SEL);
    wire wr_prio = wr_en && (addr == ADDR_IRQ_PRIO);
    wire cmp_sel = (addr[7:3] == ADDR_CMP_BLOCK) && (addr[2:1] != 2'h3);
    wire cap_sel = (addr[7:3] == ADDR_CAP_BLOCK);
    wire [1:0] reg_idx = addr[2:1];
    wire hi_byte = addr[0];

    logic [7:0] edge_sel_r;
    logic [HW_SET_BITS-1:0] set_en_r;
    logic [7:0] rt_en_r;
    logic [7:0] prio_r;
    logic [7:0] flags_r;
    logic [7:0] ctrl_r;
    logic [7:0] port_r;
    logic [1:0] toggle_r;
    logic [TIMER_W-1:0] cmp_r [NUM_CMP];
    logic [TIMER_W-1:0] cap_r [NUM_CAP];

    // capture inputs: sampled once per machine cycle
    wire [NUM_CAP-1:0] cap_in = {capture_input_3, capture_input_2,
                                 capture_input_1, capture_input_0};
    logic [NUM_CAP-1:0] samp_r;
    logic [NUM_CAP-1:0] prev_r;
    logic [NUM_CAP-1:0] cap_hit;
    logic [NUM_CAP-1:0] cap_flag_set;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            samp_r <= '0;
            prev_r <= '0;
        end else if (in_s1) begin
            samp_r <= cap_in;
            prev_r <= samp_r;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CAP; gi++) begin : g_cap
            wire rise = samp_r[gi] && !prev_r[gi];
            wire fall = !samp_r[gi] && prev_r[gi];
            assign cap_hit[gi] = (rise && edge_sel_r[2*gi])
                || (fall && edge_sel_r[2*gi+1]);
            // early channels flag in S4, the rest in S6
            assign cap_flag_set[gi] = cap_hit[gi]
                && ((gi < EARLY_CAP_CHANNELS) ? in_s4 : in_s6);

            always_ff @(posedge core_clk) begin
                if (reset) begin
                    cap_r[gi] <= RST_WORD;
                end else if (cap_hit[gi] && in_s6) begin
                    cap_r[gi] <= timer_value;
                end
            end
        end
    endgenerate

    // compare: match found in S1 after an increment, acted on next cycle
    logic [NUM_CMP-1:0] match_r;
    logic [NUM_CMP-1:0] match_d_r;
    logic [NUM_CMP-1:0] match_now;

    generate
        for (gi = 0; gi < NUM_CMP; gi++) begin : g_cmp
            assign match_now[gi] = timer_tick
                && (timer_value == cmp_r[gi]);

            always_ff @(posedge core_clk) begin
                if (reset) begin
                    cmp_r[gi] <= RST_WORD;
                end else if (wr_en && cmp_sel && (reg_idx == gi)) begin
                    if (hi_byte) begin
                        cmp_r[gi][15:8] <= wr_data;
                    end else begin
                        cmp_r[gi][7:0] <= wr_data;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk) begin
        if (reset) begin
            match_r <= '0;
            match_d_r <= '0;
        end else if (in_s1) begin
            match_r <= match_now;
            match_d_r <= match_r;
        end
    end

    // port modification by hardware, applied in S5 of the cycle after a match
    wire [5:0] hw_set = set_en_r & {6{match_d_r[0]}};
    wire [5:0] hw_clr = rt_en_r[5:0] & {6{match_d_r[1]}};
    wire [1:0] hw_tog = rt_en_r[7:6] & {2{match_d_r[2]}};
    wire hw_apply = in_s5;
    wire [7:0] hw_mask = hw_apply ? {hw_tog, hw_set | hw_clr} : 8'h00;
    // clear beats set on the same bit
    wire [5:0] hw_low = (port_r[5:0] | hw_set) & ~hw_clr;
    wire [1:0] hw_high = (hw_tog & toggle_r) | (~hw_tog & port_r[7:6]);

    // software port writes wait for the next S1; bits touched by hardware
    // in the same machine cycle are dropped so the compare result stands
    logic [7:0] sw_val_r;
    logic [7:0] sw_mask_r;
    logic [7:0] hw_cyc_r;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            hw_cyc_r <= RST_BYTE;
        end else if (in_s1) begin
            hw_cyc_r <= RST_BYTE;
        end else begin
            hw_cyc_r <= hw_cyc_r | hw_mask;
        end
    end

    wire [7:0] sw_block = hw_cyc_r | hw_mask;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            sw_val_r <= RST_BYTE;
            sw_mask_r <= RST_BYTE;
        end else if (wr_port) begin
            sw_val_r <= wr_data;
            sw_mask_r <= ~sw_block;
        end else if (in_s1) begin
            sw_mask_r <= RST_BYTE;
        end else begin
            sw_mask_r <= sw_mask_r & ~hw_mask;
        end
    end

    wire [7:0] port_sw = (sw_val_r & sw_mask_r) | (port_r & ~sw_mask_r);

    always_ff @(posedge core_clk) begin
        if (reset) begin
            port_r <= RST_BYTE;
            toggle_r <= RST_TOGGLE;
        end else if (hw_apply) begin
            port_r <= {hw_high, hw_low};
            toggle_r <= toggle_r ^ hw_tog;
        end else if (in_s1) begin
            port_r <= port_sw;
        end
    end

    // interrupt flags; a hardware set wins over a software clear
    logic ovf_byte_pend_r;
    logic ovf_wide_pend_r;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            ovf_byte_pend_r <= 1'b0;
            ovf_wide_pend_r <= 1'b0;
        end else if (in_s6) begin
            ovf_byte_pend_r <= 1'b0;
            ovf_wide_pend_r <= 1'b0;
        end else begin
            ovf_byte_pend_r <= ovf_byte_pend_r | byte_overflow;
            ovf_wide_pend_r <= ovf_wide_pend_r | wide_overflow;
        end
    end

    wire wide_set = in_s6 && (ovf_wide_pend_r || wide_overflow);
    // a wide overflow is also a low-byte overflow
    wire byte_set = in_s6 && (ovf_byte_pend_r || byte_overflow
        || ovf_wide_pend_r || wide_overflow);
    wire [2:0] match_set = in_s6 ? match_d_r : 3'h0;

    wire [7:0] flag_set = {wide_set, match_set, cap_flag_set};
    wire [7:0] flags_nxt = (wr_flags ? wr_data : flags_r) | flag_set;
    wire [7:0] ctrl_set = {3'h0, byte_set, 4'h0};
    wire [7:0] ctrl_nxt = (wr_ctrl ? wr_data : ctrl_r) | ctrl_set;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            flags_r <= RST_BYTE;
            ctrl_r <= RST_BYTE;
            edge_sel_r <= RST_BYTE;
            set_en_r <= '0;
            rt_en_r <= RST_BYTE;
            prio_r <= RST_BYTE;
        end else begin
            flags_r <= flags_nxt;
            ctrl_r <= ctrl_nxt;
            if (wr_edge) begin
                edge_sel_r <= wr_data;
            end
            if (wr_ste) begin
                set_en_r <= wr_data[HW_SET_BITS-1:0];
            end
            if (wr_rte) begin
                rt_en_r <= wr_data;
            end
            if (wr_prio) begin
                prio_r <= wr_data;
            end
        end
    end

    // read path
    wire [TIMER_W-1:0] cmp_word = (reg_idx == 2'h0) ? cmp_r[0]
        : (reg_idx == 2'h1) ? cmp_r[1] : cmp_r[2];
    wire [TIMER_W-1:0] cap_word = (reg_idx == 2'h0) ? cap_r[0]
        : (reg_idx == 2'h1) ? cap_r[1]
        : (reg_idx == 2'h2) ? cap_r[2] : cap_r[3];
    wire [7:0] ste_view = {toggle_r, set_en_r};
    wire [7:0] rd_mux =
        (addr == ADDR_IRQ_FLAGS) ? flags_r
        : (addr == ADDR_TIMER_CTRL) ? ctrl_r
        : (addr == ADDR_SET_EN) ? ste_view
        : (addr == ADDR_RT_EN) ? rt_en_r
        : (addr == ADDR_OUT_PORT) ? port_r
        : (addr == ADDR_EDGE_SEL) ? edge_sel_r
        : (addr == ADDR_IRQ_PRIO) ? prio_r
        : cmp_sel ? (hi_byte ? cmp_word[15:8] : cmp_word[7:0])
        : cap_sel ? (hi_byte ? cap_word[15:8] : cap_word[7:0])
        : RST_BYTE;

    logic [7:0] rd_data_r;

    // read data shows the flags as they stand at the read edge, so a
    // capture flagged in S4 is visible to an S5 read two states before an
    // S6 flag would be
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rd_data_r <= RST_BYTE;
        end else if (rd_en) begin
            rd_data_r <= rd_mux;
        end else begin
            rd_data_r <= RST_BYTE;
        end
    end

    assign rd_data = rd_data_r;
    assign output_port = port_r;
    assign timer_irq_flags = flags_r;
    assign byte_overflow_flag = ctrl_r[CTRL_BYTE_OVF_BIT];
    assign timer_irq_priority = prio_r;

endmodule // tccu_top

`default_nettype wire

// [tb/tccu_chk.sv]
// tccu_chk: port-level assertions for tccu_top.
// assumes a bind from the bench; one clock, sync active-high reset.
`timescale 1ns/100ps
`default_nettype none
module tccu_chk
    import tccu_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] rd_data,
    input wire logic byte_overflow,
    input wire logic wide_overflow,
    input wire logic [7:0] output_port,
    input wire logic [7:0] timer_irq_flags,
    input wire logic byte_overflow_flag,
    input wire logic [7:0] timer_irq_priority
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence s_rd(logic [7:0] a);
        rd_en && addr == a ##1 1'b1;
    endsequence
    property p_rst_zero;
        $fell(reset) |-> output_port == 8'h00 && timer_irq_flags == 8'h00
            && timer_irq_priority == 8'h00;
    endproperty
    property p_rd_flags;
        s_rd(ADDR_IRQ_FLAGS) |-> rd_data == $past(timer_irq_flags);
    endproperty
    property p_rd_ctrl;
        s_rd(ADDR_TIMER_CTRL) |-> rd_data[4] == $past(byte_overflow_flag);
    endproperty
    property p_rd_prio;
        s_rd(ADDR_IRQ_PRIO) |-> rd_data == $past(timer_irq_priority);
    endproperty
    property p_wr_prio;
        wr_en && addr == ADDR_IRQ_PRIO |=> timer_irq_priority == $past(wr_data);
    endproperty
    // only a software write may take a flag down
    property p_sw_clear;
        !$past(wr_en && addr == ADDR_IRQ_FLAGS)
            |-> ($past(timer_irq_flags) & ~timer_irq_flags) == 8'h00;
    endproperty
    property p_ovf_wide;
        wide_overflow |-> ##[1:6] timer_irq_flags[7];
    endproperty
    property p_ovf_byte;
        byte_overflow || wide_overflow |-> ##[1:6] byte_overflow_flag;
    endproperty
    // port moves only at the end of S1 or S5, never two edges running
    property p_port_gap;
        $changed(output_port) |=> $stable(output_port);
    endproperty
    a_rst_zero: assert property (p_rst_zero)
        else $error("outputs not cleared by reset");
    a_rd_flags: assert property (p_rd_flags)
        else $error("flag read mismatch");
    a_rd_ctrl: assert property (p_rd_ctrl)
        else $error("byte overflow read mismatch");
    a_rd_prio: assert property (p_rd_prio)
        else $error("priority read mismatch");
    a_wr_prio: assert property (p_wr_prio)
        else $error("priority write lost");
    a_sw_clear: assert property (p_sw_clear)
        else $error("flag cleared without software");
    a_ovf_wide: assert property (p_ovf_wide)
        else $error("wide overflow flag late");
    a_ovf_byte: assert property (p_ovf_byte)
        else $error("byte overflow flag late");
    a_port_gap: assert property (p_port_gap)
        else $error("port changed on adjacent edges");
endmodule // tccu_chk
`default_nettype wire

// [tb/tccu_partner.sv]
// tccu_partner: free-running timer with machine-cycle phase and the
// capture event lines; assumes phase 0 is S1 in the cycle after reset.
`timescale 1ns/100ps
`default_nettype none
module tccu_partner #(
    parameter logic [15:0] START = 16'hfe00
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [3:0] cap_lvl,
    output logic [2:0] phase,
    output logic [15:0] timer_value,
    output logic timer_tick,
    output logic byte_overflow,
    output logic wide_overflow,
    output logic [3:0] cap_pins
);
    always_ff @(posedge core_clk) begin
        if (reset) begin
            phase <= 3'h0;
            timer_value <= START;
            cap_pins <= 4'h0;
        end else begin
            phase <= (phase == 3'h5) ? 3'h0 : phase + 3'h1;
            if (phase == 3'h5)
                timer_value <= timer_value + 16'h0001;
            // moved mid-cycle so the S1 sample never sees a change in flight
            if (phase == 3'h2)
                cap_pins <= cap_lvl;
        end
    end
    assign timer_tick = phase == 3'h0 && !reset;
    assign byte_overflow = phase == 3'h5 && timer_value[7:0] == 8'hff;
    assign wide_overflow = phase == 3'h5 && timer_value == 16'hffff;
endmodule // tccu_partner
`default_nettype wire

// [tb/tccu_top_tb.sv]
// tccu_top_tb: directed bench for the capture/compare block.
// assumes tccu_partner supplies the timer and the capture lines.
`timescale 1ns/100ps
`default_nettype none
module tccu_top_tb;
    import tccu_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wr_data = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [3:0] cap_lvl = 4'h0;
    logic [7:0] rd_data, output_port, timer_irq_flags, timer_irq_priority, rv;
    logic byte_overflow_flag, timer_tick, byte_overflow, wide_overflow;
    logic [2:0] phase;
    logic [15:0] timer_value, t;
    logic [3:0] cap_pins;
    logic [7:0] ra [8] = '{ADDR_IRQ_FLAGS, ADDR_TIMER_CTRL, ADDR_SET_EN,
        ADDR_RT_EN, ADDR_OUT_PORT, ADDR_EDGE_SEL, ADDR_IRQ_PRIO, 8'h55};
    int error_cnt = 0;
    int check_count = 0;
    always #12.5 core_clk = ~core_clk;
    tccu_top i_tccu_top (.core_clk(core_clk), .reset(reset), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .timer_value(timer_value), .timer_tick(timer_tick),
        .byte_overflow(byte_overflow), .wide_overflow(wide_overflow),
        .capture_input_0(cap_pins[0]), .capture_input_1(cap_pins[1]),
        .capture_input_2(cap_pins[2]), .capture_input_3(cap_pins[3]),
        .output_port(output_port), .timer_irq_flags(timer_irq_flags),
        .byte_overflow_flag(byte_overflow_flag),
        .timer_irq_priority(timer_irq_priority));
    tccu_partner i_tccu_partner (.core_clk(core_clk), .reset(reset),
        .cap_lvl(cap_lvl), .phase(phase), .timer_value(timer_value),
        .timer_tick(timer_tick), .byte_overflow(byte_overflow),
        .wide_overflow(wide_overflow), .cap_pins(cap_pins));
    task automatic results;
        if (error_cnt == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] got, exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge core_clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge core_clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1 rv = rd_data;
    endtask
    // any ignores the timer value and waits for the phase alone
    task automatic wait_at(input logic [15:0] v, input logic [2:0] p,
        input bit any);
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            #1 n++;
        end while (!((any || timer_value == v) && phase == p) && n < 6000);
        if (n >= 6000)
            chk("wait", 8'h00, 8'h01);
    endtask
    task automatic t_cmp;
        logic [15:0] m;
        m = timer_value + 16'h0006;
        for (int j = 0; j < 3; j++) begin
            wr(8'hd0 + 8'(2 * j), m[7:0]);
            wr(8'hd1 + 8'(2 * j), m[15:8]);
        end
        wr(ADDR_RT_EN, 8'hcc);
        wr(ADDR_OUT_PORT, 8'h30);
        wait_at(m + 16'h1, 3'h4, 1'b0);
        chk("port early", output_port, 8'h30);
        wait_at(m + 16'h1, 3'h5, 1'b0);
        chk("port", output_port, 8'hf3);
        chk("match early", timer_irq_flags & 8'h70, 8'h00);
        wait_at(m + 16'h2, 3'h0, 1'b0);
        chk("match flags", timer_irq_flags & 8'h70, 8'h70);
        rd(ADDR_SET_EN);
        chk("toggle state", rv, 8'h0f);
        wr(ADDR_OUT_PORT, 8'h00);
        for (int k = 0; k < 2; k++) begin
            m = timer_value + 16'h0004;
            wr(8'hd4, m[7:0]);
            wr(8'hd5, m[15:8]);
            wait_at(m + 16'h2, 3'h0, 1'b0);
            chk("toggle", output_port, k ? 8'hc0 : 8'h00);
        end
        rd(ADDR_OUT_PORT);
        chk("port read", rv, 8'hc0);
    endtask
    task automatic t_cap(input logic [3:0] lvl, early, late,
        input logic [7:0] ca);
        wr(ADDR_IRQ_FLAGS, 8'h00);
        wait_at(16'h0, 3'h4, 1'b1);
        @(posedge core_clk);
        cap_lvl <= lvl;
        wait_at(16'h0, 3'h3, 1'b1);
        wait_at(16'h0, 3'h0, 1'b1);
        t = timer_value;
        // the S4 flag lands on the edge that ends S4, so look in S6 before the S6 flags land
        wait_at(16'h0, 3'h5, 1'b1);
        chk("early", {4'h0, timer_irq_flags[3:0]}, {4'h0, early});
        wait_at(16'h0, 3'h0, 1'b1);
        chk("late", {4'h0, timer_irq_flags[3:0]}, {4'h0, early | late});
        rd(ca);
        chk("capture lo", rv, t[7:0]);
        rd(ca + 8'h01);
        chk("capture hi", rv, t[15:8]);
    endtask
    task automatic t_ovf;
        wait_at(16'hfff0, 3'h0, 1'b0);
        wr(ADDR_IRQ_FLAGS, 8'h00);
        wr(ADDR_TIMER_CTRL, 8'h00);
        wait_at(16'hffff, 3'h5, 1'b0);
        chk("ovf early", {6'h0, timer_irq_flags[7], byte_overflow_flag},
            8'h00);
        wait_at(16'h0000, 3'h0, 1'b0);
        chk("ovf", {6'h0, timer_irq_flags[7], byte_overflow_flag},
            8'h03);
    endtask
    task automatic t_rst;
        logic [7:0] a;
        @(posedge core_clk);
        reset <= 1'b1;
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        for (int i = 0; i < 14; i++) begin
            a = (i < 6) ? 8'hd0 + 8'(i) : ra[i - 6];
            rd(a);
            chk("reset value", rv, (a == ADDR_SET_EN) ? 8'hc0 : 8'h00);
        end
        chk("port reset", output_port, 8'h00);
    endtask
    initial begin
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        wr(ADDR_IRQ_PRIO, 8'ha5);
        rd(ADDR_IRQ_PRIO);
        chk("prio read", rv, 8'ha5);
        chk("prio port", timer_irq_priority, 8'ha5);
        wr(ADDR_EDGE_SEL, 8'h79);
        rd(ADDR_EDGE_SEL);
        chk("edge select", rv, 8'h79);
        wr(ADDR_SET_EN, 8'h0f);
        rd(ADDR_SET_EN);
        chk("set enable", rv, 8'hcf);
        t_cmp();
        t_cap(4'hf, 4'h1, 4'hc, 8'he0);
        t_cap(4'h0, 4'h2, 4'h4, 8'he2);
        t_ovf();
        t_rst();
        results();
    end
    initial begin
        #(25 * 20000);
        error_cnt++;
        results();
    end
endmodule // tccu_top_tb
bind tccu_top tccu_chk i_tccu_chk (.core_clk(core_clk), .reset(reset),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .byte_overflow(byte_overflow),
    .wide_overflow(wide_overflow), .output_port(output_port),
    .timer_irq_flags(timer_irq_flags),
    .byte_overflow_flag(byte_overflow_flag),
    .timer_irq_priority(timer_irq_priority));
`default_nettype wire
